// ---- shared/lnt_consts.vh ----
// Constants for the single-wire bus transceiver mode and signal control.
// Assumes a 250 MHz clock; all pins arrive already digitised.
`ifndef LNT_CONSTS_VH
`define LNT_CONSTS_VH

`define LNT_CLK_MHZ          250
// Filter and protection times, in their printed units
`define LNT_BUS_WAKE_US      90
`define LNT_LOCAL_WAKE_US    35
`define LNT_DOM_TIMEOUT_MS   40
`define LNT_RELEASE_US       10
`define LNT_ACTIVATE_US      10
`define LNT_WAKE_REARM_US    6
// Cycle counts at 250 cycles per microsecond, sized to the counters
`define LNT_BUS_WAKE_CYC     24'h0057e4
`define LNT_LOCAL_WAKE_CYC   24'h00222e
`define LNT_DOM_TIMEOUT_CYC  24'h989680
`define LNT_RELEASE_CYC      24'h0009c4
`define LNT_ACTIVATE_CYC     24'h0009c4
`define LNT_WAKE_REARM_CYC   24'h0005dc

`define LNT_CNT_W            24
// Mode encodings
`define LNT_ST_SLEEP         2'h0
`define LNT_ST_FAILSAFE      2'h1
`define LNT_ST_NORMAL        2'h2

`endif

// ---- src/lnt_pin_sync.v ----
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin and one system clock.
`include "lnt_consts.vh"
`default_nettype none

module lnt_pin_sync #(
    parameter [0:0] INIT = 1'h0
) (
    // Clock and reset
    input  wire clock,
    input  wire sys_rst,
    // Pin and clean level
    input  wire pin_in,
    output reg  level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // First stage read only by second; level moves once 2 and 3 agree
    always @(posedge clock) begin
        if (sys_rst) begin
            s1_r    <= INIT;
            s2_r    <= INIT;
            s3_r    <= INIT;
            level_r <= INIT;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level_r <= s3_r;
        end
    end
endmodule

`default_nettype wire

// ---- src/lnt_level_timer.v ----
// Counts how long a level has held; flags once a minimum time is reached.
// Assumes a clean same-clock input.
`include "lnt_consts.vh"
`default_nettype none

module lnt_level_timer #(
    parameter [`LNT_CNT_W-1:0] LIMIT = 24'h000001
) (
    // Clock and reset
    input  wire clock,
    input  wire sys_rst,
    // Level being timed and result
    input  wire active,
    output wire reached
);
    reg [`LNT_CNT_W-1:0] cnt_r;

    // Saturating count restarts whenever the level drops
    always @(posedge clock) begin
        if (sys_rst || !active)
            cnt_r <= {`LNT_CNT_W{1'b0}};
        else if (cnt_r != LIMIT)
            cnt_r <= cnt_r + 24'h000001;
    end

    assign reached = active && (cnt_r == LIMIT);
endmodule

`default_nettype wire

// ---- src/lnt_mode_ctrl.v ----
// Mode and pin control of a single-wire bus transceiver.
// Assumes pins are digitised levels; supply monitor gives a level flag.
// Bus level is 1 recessive, 0 dominant. Power-on drives sys_rst.
`include "lnt_consts.vh"
`default_nettype none

module lnt_mode_ctrl #(
    parameter [0:0] TIMEOUT_EN = 1'h1,
    parameter [`LNT_CNT_W-1:0] DOM_TIMEOUT_CYC = `LNT_DOM_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire clock,
    input  wire sys_rst,
    // Controller side pins
    input  wire en_pin,
    input  wire txd_in,
    output reg  txd_out,
    output reg  txd_oe,
    output reg  txd_strong,
    output reg  rxd_out,
    output reg  rxd_oe,
    // Local wake pin, active low
    input  wire wake_n_pin,
    // Supply and regulator
    input  wire battery_supply_ok,
    output reg  regulator_switch_out,
    // Bus side
    input  wire bus_in,
    output reg  bus_dominant,
    output reg  bus_term_en,
    output reg  bus_weak_pullup,
    // Mode visibility
    output wire [1:0] mode
);
    // Mode codes
    localparam [1:0] ST_SLEEP    = `LNT_ST_SLEEP;
    localparam [1:0] ST_FAILSAFE = `LNT_ST_FAILSAFE;
    localparam [1:0] ST_NORMAL   = `LNT_ST_NORMAL;

    // Clean pin levels after the synchronisers
    wire en_s;
    wire txd_s;
    wire wake_n_s;
    wire bus_s;
    wire vs_ok_s;

    // All pins come from outside the clock domain
    // Mode select; open pin reads low
    lnt_pin_sync #(.INIT(1'h0)) u_en (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (en_pin),
        .level_r (en_s)
    );
    // Transmit level, recessive after reset
    lnt_pin_sync #(.INIT(1'h1)) u_txd (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (txd_in),
        .level_r (txd_s)
    );
    // Local wake, idle high so no false wake after reset
    lnt_pin_sync #(.INIT(1'h1)) u_wake (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (wake_n_pin),
        .level_r (wake_n_s)
    );
    // Bus level, recessive after reset
    lnt_pin_sync #(.INIT(1'h1)) u_bus (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (bus_in),
        .level_r (bus_s)
    );
    // Supply flag; assumed low until seen good
    lnt_pin_sync #(.INIT(1'h0)) u_vs (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (battery_supply_ok),
        .level_r (vs_ok_s)
    );

    // Mode state and sticky flags
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg       en_d_r;
    reg       wake_req_r;   // Wake request shown on RXD
    reg       wake_local_r; // Source: 1 local, 0 remote
    reg       drv_armed_r;  // Driver allowed after activation time
    reg       dom_lock_r;   // Dominant timeout tripped
    reg       wake_armed_r; // Local wake needs high before a new edge
    reg       bus_seen_dom_r;

    wire in_sleep = (state_r == ST_SLEEP);
    wire bus_wake_done;
    wire local_wake_done;
    wire txd_high_act;
    wire txd_high_rel;
    wire wake_high_rearm;
    wire dom_long;

    lnt_level_timer #(.LIMIT(`LNT_BUS_WAKE_CYC)) u_bus_flt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (in_sleep && !bus_s),
        .reached (bus_wake_done)
    );
    lnt_level_timer #(.LIMIT(`LNT_LOCAL_WAKE_CYC)) u_wake_flt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (in_sleep && !wake_n_s && wake_armed_r),
        .reached (local_wake_done)
    );
    // Wake must be high a while before a new low counts
    lnt_level_timer #(.LIMIT(`LNT_WAKE_REARM_CYC)) u_wake_rearm (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (wake_n_s),
        .reached (wake_high_rearm)
    );
    lnt_level_timer #(.LIMIT(`LNT_ACTIVATE_CYC)) u_act (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (state_r == ST_NORMAL && txd_s),
        .reached (txd_high_act)
    );
    // TXD high time to clear timeout
    lnt_level_timer #(.LIMIT(`LNT_RELEASE_CYC)) u_rel (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (txd_s),
        .reached (txd_high_rel)
    );
    lnt_level_timer #(.LIMIT(DOM_TIMEOUT_CYC)) u_dom (
        .clock   (clock),
        .sys_rst (sys_rst),
        .active  (state_r == ST_NORMAL && !txd_s && TIMEOUT_EN),
        .reached (dom_long)
    );

    // Remote wake needs the rising edge after a long enough dominant
    wire remote_wake = in_sleep && bus_seen_dom_r && bus_s;
    wire local_wake  = local_wake_done;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_SLEEP: begin
                if (local_wake || remote_wake)
                    state_nxt = ST_FAILSAFE;
                // EN rising goes straight to normal
                else if (en_s && !en_d_r)
                    state_nxt = ST_NORMAL;
            end
            ST_FAILSAFE: begin
                if (en_s)
                    state_nxt = ST_NORMAL;
            end
            ST_NORMAL: begin
                if (!en_s && en_d_r && txd_s)
                    state_nxt = ST_SLEEP;
                else if (!en_s)
                    state_nxt = ST_SLEEP;
            end
            default: state_nxt = ST_FAILSAFE;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            state_r        <= ST_FAILSAFE;
            en_d_r         <= 1'h0;
            wake_req_r     <= 1'h0;
            wake_local_r   <= 1'h0;
            drv_armed_r    <= 1'h0;
            dom_lock_r     <= 1'h0;
            wake_armed_r   <= 1'h1;
            bus_seen_dom_r <= 1'h0;
        end else begin
            // Mode and edge history
            state_r <= state_nxt;
            en_d_r  <= en_s;
            // Dominant long enough; wake fires on the next recessive
            if (!in_sleep || bus_s && bus_seen_dom_r)
                bus_seen_dom_r <= 1'h0;
            else if (bus_wake_done)
                bus_seen_dom_r <= 1'h1;
            // Continuous low on wake does not retrigger after sleep
            if (local_wake)
                wake_armed_r <= 1'h0;
            else if (wake_high_rearm)
                wake_armed_r <= 1'h1;
            // EN high clears indications; wake set wins
            if (local_wake || remote_wake) begin
                wake_req_r   <= 1'h1;
                wake_local_r <= local_wake;
            end else if (en_s) begin
                wake_req_r   <= 1'h0;
                wake_local_r <= 1'h0;
            end
            // driver re-armed only after TXD high time
            if (state_r != ST_NORMAL)
                drv_armed_r <= 1'h0;
            else if (txd_high_act)
                drv_armed_r <= 1'h1;
            // trip on long dominant; clear after release
            if (dom_long)
                dom_lock_r <= 1'h1;
            else if (txd_high_rel)
                dom_lock_r <= 1'h0;
        end
    end

    assign mode = state_r;

    // Wake indication as the pins must show it this cycle
    wire wake_now  = local_wake || remote_wake;
    wire wake_flag = wake_req_r || wake_now;
    wire wake_loc  = local_wake || (wake_req_r && wake_local_r);
    // Outputs follow the next state, so they change with the mode
    wire nxt_sleep  = (state_nxt == ST_SLEEP);
    wire nxt_fs     = (state_nxt == ST_FAILSAFE);
    wire nxt_normal = (state_nxt == ST_NORMAL);

    // TXD low gives dominant in normal mode
    // undervoltage blocks; lock and arming gate too
    always @(posedge clock) begin
        if (sys_rst) begin
            bus_dominant <= 1'h0;
        end else begin
            bus_dominant <= nxt_normal && drv_armed_r && !dom_lock_r &&
                            !txd_s && vs_ok_s;
        end
    end

    // only the weak pull-up while asleep
    always @(posedge clock) begin
        if (sys_rst) begin
            bus_term_en     <= 1'h1;
            bus_weak_pullup <= 1'h0;
        end else begin
            bus_term_en     <= !nxt_sleep;
            bus_weak_pullup <= nxt_sleep;
        end
    end

    // regulator switch on except in sleep
    // a wake leaves sleep, so the switch follows; low supply holds off
    always @(posedge clock) begin
        if (sys_rst) begin
            regulator_switch_out <= 1'h1;
        end else begin
            regulator_switch_out <= !nxt_sleep && vs_ok_s;
        end
    end

    // RXD follows the bus in normal mode
    // in fail-safe a low RXD marks a pending wake request
    always @(posedge clock) begin
        if (sys_rst) begin
            rxd_out <= 1'h1;
            rxd_oe  <= 1'h0;
        end else if (nxt_normal) begin
            rxd_out <= bus_s;
            rxd_oe  <= !bus_s;
        end else if (nxt_fs) begin
            rxd_out <= !wake_flag;
            rxd_oe  <= wake_flag;
        end else begin
            // Open drain released: pin floats in sleep
            rxd_out <= 1'h1;
            rxd_oe  <= 1'h0;
        end
    end

    // TXD pin pulled down in fail-safe to show the source
    // strong pull-down for local wake, weak for remote
    always @(posedge clock) begin
        if (sys_rst) begin
            txd_out    <= 1'h0;
            txd_oe     <= 1'h0;
            txd_strong <= 1'h0;
        end else begin
            txd_out    <= 1'h0;
            txd_oe     <= nxt_fs && wake_flag;
            txd_strong <= nxt_fs && wake_loc;
        end
    end
endmodule

`default_nettype wire

// ---- sim/lnt_mcu_model.sv ----
// Controller model: drives mode select and transmit pins.
// Assumes the bench calls its tasks from one process only.
`default_nettype none
module lnt_mcu_model (
    // Clock
    input  wire logic clock,
    // Pins to the transceiver
    output var  logic en_pin,
    output var  logic txd_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins idle: sleep request, transmit recessive
    initial begin
        en_pin = 1'h0;
        txd_in = 1'h1;
    end

    task automatic drive(input logic v, input int n);
        @(negedge clock);
        txd_in = v;
        repeat (n) @(negedge clock);
    endtask

    task automatic set_en(input logic v);
        @(negedge clock);
        if (!v) begin
            txd_in = 1'h1;
        end
        @(negedge clock);
        en_pin = v;
    endtask
endmodule
`default_nettype wire

// ---- sim/lnt_mode_ctrl_assertions.sv ----
// Checker for the mode control, bound to the top module's ports.
// Assumes pins settle within eight cycles of the synchronisers.
`default_nettype none
module lnt_mode_ctrl_checker #(
    parameter int DOM_TIMEOUT_CYC = 200
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Controller side
    input wire logic       en_pin,
    input wire logic       txd_in,
    input wire logic       txd_oe,
    input wire logic       rxd_oe,
    // Supply and regulator
    input wire logic       battery_supply_ok,
    input wire logic       regulator_switch_out,
    // Bus side
    input wire logic       bus_in,
    input wire logic       bus_dominant,
    input wire logic       bus_term_en,
    input wire logic       bus_weak_pullup,
    input wire logic [1:0] mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic [31:0] dom_cnt_r;

    // Dominant run length; stuck driver shows as a long run
    always_ff @(posedge clock) begin
        if (sys_rst || !bus_dominant) begin
            dom_cnt_r <= 32'h0;
        end else begin
            dom_cnt_r <= dom_cnt_r + 32'h1;
        end
    end

    sequence s_en_low;
        (!en_pin)[*8];
    endsequence
    sequence s_en_high;
        en_pin[*8];
    endsequence

    a_sleep_pins_off: assert property (
        (mode == 2'h0)[*2] |-> !regulator_switch_out && !bus_term_en
            && bus_weak_pullup) else $error("sleep pin levels wrong");
    a_quiet_not_normal: assert property (
        (mode != 2'h2)[*2] |-> !bus_dominant)
        else $error("dominant outside normal mode");
    a_mode_code_legal: assert property (
        mode != 2'h3) else $error("illegal mode code");
    a_txd_high_recessive: assert property (
        txd_in[*8] |-> !bus_dominant) else $error("dominant with txd high");
    a_undervolt_no_tx: assert property (
        (!battery_supply_ok)[*8] |-> !bus_dominant)
        else $error("dominant in undervoltage");
    a_rxd_bus_level: assert property (
        (mode == 2'h2 && bus_in)[*8] |-> !rxd_oe)
        else $error("rxd low on recessive bus");
    a_en_low_leaves: assert property (
        s_en_low |-> mode != 2'h2) else $error("normal with en low");
    a_en_clears_flags: assert property (
        s_en_high |-> !txd_oe) else $error("wake source not cleared");
    a_wake_reg_on: assert property (
        $rose(txd_oe) |-> ##[0:1] mode == 2'h1 && regulator_switch_out)
        else $error("wake without fail-safe");
    a_dom_time_limit: assert property (
        dom_cnt_r <= DOM_TIMEOUT_CYC + 8) else $error("dominant too long");
endmodule
bind lnt_mode_ctrl lnt_mode_ctrl_checker #(
    .DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)
) chk (.*);
`default_nettype wire

// ---- sim/lnt_mode_ctrl_test.sv ----
// Bench for the mode control: one task per scenario.
// Assumes the controller model and the bound checker are compiled.
`default_nettype none
module lnt_mode_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, sys_rst, en_pin, txd_in, txd_out, txd_oe;
    logic       txd_strong, rxd_out, rxd_oe, wake_n_pin, bus_in;
    logic       battery_supply_ok, regulator_switch_out, bus_dominant;
    logic       bus_term_en, bus_weak_pullup, bus_low;
    logic [1:0] mode;
    int         failures = 0;
    int         tests_run = 0;

    // Short timeout keeps the run brief
    lnt_mode_ctrl #(.DOM_TIMEOUT_CYC(24'h0000c8)) uut (.*);
    lnt_mcu_model mcu (.clock(clock), .en_pin(en_pin), .txd_in(txd_in));
    // Bus has a pull-up: low only if someone pulls it
    assign bus_in = ~(bus_dominant | bus_low);

    initial clock = 1'h0;
    always #2 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input string n, input logic [1:0] s, e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic t_reset;
        cyc(10);
        chk("mode", mode, 2'h1);
        chk("inh", regulator_switch_out, 1'h1);
        chk("term", bus_term_en, 1'h1);
    endtask

    task automatic t_normal;
        mcu.drive(1'h0, 1);
        mcu.set_en(1'h1);
        cyc(20);
        chk("mode", mode, 2'h2);
        chk("unarmed", bus_dominant, 1'h0);
        mcu.drive(1'h1, 2600);
        mcu.drive(1'h0, 10);
        chk("dom", bus_dominant, 1'h1);
        chk("rxd_dom", rxd_oe, 1'h1);
        chk("rxd_lvl_dom", rxd_out, 1'h0);
        mcu.drive(1'h1, 10);
        chk("rec", bus_dominant, 1'h0);
        chk("rxd_rec", rxd_oe, 1'h0);
        chk("rxd_lvl_rec", rxd_out, 1'h1);
    endtask

    task automatic t_timeout;
        mcu.drive(1'h0, 100);
        chk("dom_pre", bus_dominant, 1'h1);
        cyc(130);
        chk("dom_cut", bus_dominant, 1'h0);
        mcu.drive(1'h1, 100);
        mcu.drive(1'h0, 10);
        chk("short_rel", bus_dominant, 1'h0);
        mcu.drive(1'h1, 2600);
        mcu.drive(1'h0, 10);
        chk("rearmed", bus_dominant, 1'h1);
        mcu.drive(1'h1, 10);
    endtask

    task automatic t_undervolt;
        mcu.drive(1'h0, 1);
        battery_supply_ok = 1'h0;
        cyc(10);
        chk("dom_uv", bus_dominant, 1'h0);
        battery_supply_ok = 1'h1;
        mcu.drive(1'h1, 10);
    endtask

    task automatic t_sleep;
        mcu.set_en(1'h0);
        cyc(10);
        chk("sleep", mode, 2'h0);
        chk("inh_off", regulator_switch_out, 1'h0);
        chk("term_off", bus_term_en, 1'h0);
        chk("weak_pu", bus_weak_pullup, 1'h1);
    endtask

    task automatic t_local;
        wake_n_pin = 1'h0;
        cyc(8000);
        chk("early", mode, 2'h0);
        cyc(1000);
        chk("fs", mode, 2'h1);
        chk("inh_on", regulator_switch_out, 1'h1);
        chk("txd_pull", txd_oe, 1'h1);
        chk("txd_low", txd_out, 1'h0);
        chk("strong", txd_strong, 1'h1);
        chk("rxd_flag", rxd_oe, 1'h1);
        mcu.set_en(1'h1);
        cyc(10);
        chk("norm", mode, 2'h2);
        chk("txd_clr", txd_oe, 1'h0);
        chk("rxd_clr", rxd_oe, 1'h0);
        wake_n_pin = 1'h1;
        mcu.set_en(1'h0);
        cyc(1600);
    endtask

    task automatic t_remote;
        bus_low = 1'h1;
        cyc(20000);
        chk("bus_early", mode, 2'h0);
        cyc(3000);
        bus_low = 1'h0;
        cyc(10);
        chk("fs_rw", mode, 2'h1);
        chk("weak", txd_strong, 1'h0);
        chk("src", txd_oe, 1'h1);
        chk("rxd_rw", rxd_oe, 1'h1);
    endtask

    // Watchdog, well past the expected run
    initial begin
        #240000;
        failures++;
        test_done;
    end

    // Main sequence
    initial begin
        sys_rst = 1'h1;
        wake_n_pin = 1'h1;
        battery_supply_ok = 1'h1;
        bus_low = 1'h0;
        cyc(4);
        sys_rst = 1'h0;
        t_reset;
        t_normal;
        t_timeout;
        t_undervolt;
        t_sleep;
        t_local;
        t_remote;
        test_done;
    end
endmodule
`default_nettype wire
